//--- testbench/touch_baseline_state_tracker_tb_top.sv
/*
  Self-checking bench for the touch baseline tracker.
  Assumes the package, header, design and models are compiled first.
*/
`timescale 1ns/100ps

module touch_baseline_state_tracker_tb_top;
  logic core_clk, rst, meas_valid, mutual_cap_method, out_valid, out_method;
  logic shield_en, override_en;
  touch_pkg::meas_t meas;
  touch_pkg::tune_t tune;
  logic [7:0] override_mask, to_shield, to_ground, touch_on;
  logic [2:0] out_sensor;
  logic signed [16:0] out_signal;
  logic [15:0] out_baseline;
  int mismatches, n_compared, cycles;

  touch_baseline_state_tracker uut (.core_clk, .rst, .meas_valid, .meas,
    .mutual_cap_method, .tune, .shield_en, .override_en, .override_mask,
    .to_shield, .to_ground, .touch_on, .out_valid, .out_sensor, .out_signal,
    .out_baseline, .out_method);
  touch_front_end_model fe (.core_clk, .meas_valid, .meas);

  // Clock and hang guard
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One scan, then the result word one cycle later
  task automatic scan(input logic [2:0] s, input logic [15:0] raw,
                      input int sig, input int base, input logic on);
    fe.send(s, raw, n_compared % 3);
    chk(32'(out_valid), 32'h0000_0001);
    chk(32'(out_sensor), 32'(s));
    chk(32'(out_signal), sig);
    chk(32'(out_baseline), 32'(base));
    chk(32'(touch_on[s]), 32'(on));
    chk(32'(out_method), 32'(mutual_cap_method));
  endtask

  task automatic route(input logic sh, input logic ov, input logic [7:0] m,
                       input logic [7:0] e_sh, input logic [7:0] e_gnd);
    @(negedge core_clk);
    shield_en = sh;
    override_en = ov;
    override_mask = m;
    #1;
    chk(32'(to_shield), 32'(e_sh));
    chk(32'(to_ground), 32'(e_gnd));
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst = 1'b1;
    mutual_cap_method = 1'b0;
    shield_en = 1'b0;
    override_en = 1'b0;
    override_mask = 8'h00;
    tune = '{16'h0064, 16'h000a, 16'h0028, 16'h0028,
      8'h03, 4'h3, 3'h3, 1'b0};
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    scan(3'h0, 16'h03e8, 0, 1000, 1'b0);
    scan(3'h0, 16'h03f8, 16, 1002, 1'b0);
    scan(3'h0, 16'h03eb, 1, 1003, 1'b0);
    scan(3'h0, 16'h04b0, 197, 1003, 1'b0);
    scan(3'h0, 16'h04b0, 197, 1003, 1'b0);
    scan(3'h0, 16'h04b0, 197, 1003, 1'b1);
    scan(3'h0, 16'h044c, 97, 1003, 1'b1);
    scan(3'h0, 16'h0445, 90, 1003, 1'b0);
    scan(3'h0, 16'h0384, -103, 1003, 1'b0);
    scan(3'h0, 16'h0384, -103, 1003, 1'b0);
    scan(3'h0, 16'h0384, 0, 900, 1'b0);
    scan(3'h0, 16'h0352, -50, 900, 1'b0);
    scan(3'h0, 16'h0352, -50, 900, 1'b0);
    scan(3'h0, 16'h0384, 0, 900, 1'b0);
    scan(3'h0, 16'h0352, -50, 900, 1'b0);
    scan(3'h0, 16'h0352, -50, 900, 1'b0);
    scan(3'h0, 16'h0352, 0, 850, 1'b0);
    mutual_cap_method = 1'b1;
    scan(3'h1, 16'h01f4, 0, 500, 1'b0);
    scan(3'h1, 16'h0244, 80, 500, 1'b0);
    tune.auto_reset = 1'b1;
    scan(3'h1, 16'h0244, 80, 510, 1'b0);
    route(1'b1, 1'b0, 8'h00, 8'hfd, 8'h00);
    route(1'b0, 1'b0, 8'hff, 8'h00, 8'hfd);
    route(1'b1, 1'b1, 8'h0f, 8'h0d, 8'hf0);
    // Recommended tuning for an expected touch signal of 100 counts
    tune = '{16'h0050, 16'h000a, 16'h0028, 16'h0028,
      8'h1e, 4'h3, 3'h3, 1'b0};
    // Mid-run reset clears results and baselines
    @(negedge core_clk);
    rst = 1'b1;
    @(negedge core_clk);
    chk(32'(out_valid), 32'h0000_0000);
    chk(32'(out_signal), 32'h0000_0000);
    chk(32'(out_baseline), 32'h0000_0000);
    chk(32'(touch_on), 32'h0000_0000);
    rst = 1'b0;
    // Finger present at start: elevated baseline, blind until reload
    scan(3'h0, 16'h04b0, 0, 1200, 1'b0);
    for (int i = 0; i < 29; i++)
    begin
      scan(3'h0, i[0] ? 16'h044c : 16'h03e8,
           i[0] ? -100 : -200, 1200, 1'b0);
    end
    scan(3'h0, 16'h03e8, 0, 1000, 1'b0);
    scan(3'h0, 16'h044c, 100, 1000, 1'b0);
    scan(3'h0, 16'h044c, 100, 1000, 1'b0);
    scan(3'h0, 16'h044c, 100, 1000, 1'b1);
    scan(3'h0, 16'h03e8, 0, 1000, 1'b0);
    report_and_stop();
  end
endmodule

bind touch_baseline_state_tracker touch_tracker_properties #(.N(N), .W(W))
  props_i (.core_clk, .rst, .meas_valid, .meas, .mutual_cap_method, .tune,
  .shield_en, .override_en, .override_mask, .to_shield, .to_ground,
  .touch_on, .out_valid, .out_sensor, .out_signal, .out_baseline,
  .out_method);

//--- testbench/touch_front_end_model.sv
/*
  Behavioural capacitance front end handing one raw count per scan.
  Assumes calls from the bench; drives at the falling edge of core_clk.
*/
`timescale 1ns/100ps

module touch_front_end_model (
  // Clock
  input wire logic core_clk,
  // Raw count stream
  output logic meas_valid,
  output touch_pkg::meas_t meas
);
  // Idle lines at start
  initial
  begin
    meas_valid = 1'b0;
    meas = '0;
  end

  // One scan word after some idle cycles, held for one sampling edge
  task automatic send(input logic [2:0] s, input logic [15:0] raw,
                      input int idle);
    repeat (idle + 1) @(negedge core_clk);
    meas_valid = 1'b1;
    meas.sensor = s;
    meas.raw = raw;
    @(negedge core_clk);
    meas_valid = 1'b0;
    meas = ~meas;  // No stale word left on the lines
  endtask
endmodule

//--- testbench/touch_tracker_properties.sv
/*
  Port checks for the touch baseline tracker: result timing, touch state
  levels and inactive sensor routing.
  Assumes binding to the top module; one clock, async reset high.
*/
`timescale 1ns/100ps

module touch_tracker_properties #(
  parameter int N = 8,
  parameter int W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Watched inputs
  input wire logic meas_valid,
  input wire touch_pkg::meas_t meas,
  input wire logic mutual_cap_method,
  input wire touch_pkg::tune_t tune,
  input wire logic shield_en,
  input wire logic override_en,
  input wire logic [N-1:0] override_mask,
  // Watched outputs
  input wire logic [N-1:0] to_shield,
  input wire logic [N-1:0] to_ground,
  input wire logic [N-1:0] touch_on,
  input wire logic out_valid,
  input wire logic [2:0] out_sensor,
  input wire logic signed [W:0] out_signal,
  input wire logic [W-1:0] out_baseline,
  input wire logic out_method
);
  // ----------------------------------------
  // Helper levels
  // ----------------------------------------
  logic [N-1:0] act_m;
  logic signed [W+1:0] on_lvl;
  logic signed [W+1:0] off_lvl;
  assign act_m = N'(1) << out_sensor;
  assign on_lvl = $signed({2'b00, tune.finger_th}) +
                  $signed({2'b00, tune.hyst});
  assign off_lvl = $signed({2'b00, tune.finger_th}) -
                   $signed({2'b00, tune.hyst});

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence scan_taken;
    meas_valid;
  endsequence
  sequence result_shown(s, m);
    out_valid && out_sensor == s && out_method == m;
  endsequence

  a_result_next: assert property (scan_taken |=> result_shown(
    $past(meas.sensor), $past(mutual_cap_method)))
    else $error("result word missing or wrong");
  a_valid_pulse: assert property (!meas_valid |=> !out_valid)
    else $error("result without a scan");
  a_off_level: assert property (out_valid && out_signal <= off_lvl
    |-> (touch_on & act_m) == '0) else $error("touch stays on");
  a_between_keep: assert property (out_valid && out_signal > off_lvl
    && out_signal < on_lvl |-> touch_on == $past(touch_on))
    else $error("state moved between levels");
  a_on_rise: assert property ((touch_on & ~$past(touch_on)) != '0
    |-> out_valid && out_signal >= on_lvl) else $error("touch on too low");
  a_other_keep: assert property (out_valid
    |-> ((touch_on ^ $past(touch_on)) & ~act_m) == '0)
    else $error("unscanned sensor changed");
  a_idle_keep: assert property (!out_valid
    |-> $stable(touch_on) && $stable(out_baseline))
    else $error("state moved without a scan");
  a_route_shield: assert property (shield_en && !override_en
    |-> to_shield == ~act_m && to_ground == '0) else $error("shield route");
  a_route_ground: assert property (!shield_en && !override_en
    |-> to_ground == ~act_m && to_shield == '0) else $error("ground route");
  a_route_mask: assert property (override_en |->
    to_shield == (override_mask & ~act_m)
    && to_ground == (~override_mask & ~act_m)) else $error("mask route");
endmodule

//--- verilog/touch_baseline_state_tracker.sv
/*
  Per-sensor baseline tracking, signal derivation and touch state with
  debounce and hysteresis, plus inactive sensor routing.
  Assumes one raw count per sensor per scan on meas_valid, same clock.
*/
`timescale 1ns/100ps
`include "touch_cfg.svh"

module touch_baseline_state_tracker #(
  parameter int N = `TOUCH_NUM_SENSORS,
  parameter int W = `TOUCH_COUNT_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Measurement stream
  input wire logic meas_valid,
  input wire touch_pkg::meas_t meas,
  input wire logic mutual_cap_method,
  // Tuning
  input wire touch_pkg::tune_t tune,
  // Inactive sensor routing
  input wire logic shield_en,
  input wire logic override_en,
  input wire logic [N-1:0] override_mask,
  output logic [N-1:0] to_shield,
  output logic [N-1:0] to_ground,
  // Results
  output logic [N-1:0] touch_on,
  output logic out_valid,
  output logic [2:0] out_sensor,
  output logic signed [W:0] out_signal,
  output logic [W-1:0] out_baseline,
  output logic out_method
);

  // ------------------------------------------------------------
  // Per-sensor state and result registers
  // ------------------------------------------------------------
  logic [W-1:0] base_q [N];
  logic [W-1:0] base_d [N];
  logic [`TOUCH_LOWCNT_W-1:0] low_q [N];
  logic [`TOUCH_LOWCNT_W-1:0] low_d [N];
  logic [`TOUCH_DEB_W-1:0] deb_q [N];
  logic [`TOUCH_DEB_W-1:0] deb_d [N];
  logic [N-1:0] init_q;
  logic [N-1:0] init_d;
  logic [N-1:0] on_q;
  logic [N-1:0] on_d;
  logic valid_q;
  logic valid_d;
  logic [2:0] sens_q;
  logic [2:0] sens_d;
  logic signed [W:0] sig_q;
  logic signed [W:0] sig_d;
  logic [W-1:0] obase_q;
  logic [W-1:0] obase_d;
  logic method_q;
  logic method_d;
  logic [N-1:0] active_mask;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Signed difference a - b at one extra bit
  function automatic logic signed [W:0] sdiff(input logic [W-1:0] a,
                                              input logic [W-1:0] b);
    sdiff = $signed({1'b0, a}) - $signed({1'b0, b});
  endfunction

  // First-order recursive low-pass step
  function automatic logic [W-1:0] lpf(input logic [W-1:0] base,
                                       input logic [W-1:0] raw,
                                       input logic [`TOUCH_SHIFT_W-1:0] sh);
    logic signed [W:0] diff;
    logic signed [W:0] step;
    logic signed [W+1:0] sum;
    diff = sdiff(raw, base);
    step = diff >>> sh;
    if (step == '0 && diff != '0)
      step = (diff > 0) ? (W+1)'(1) : -(W+1)'(1);
    sum = $signed({2'b00, base}) + (W+2)'(step);
    lpf = sum[W-1:0];
  endfunction

  // ------------------------------------------------------------
  // Scan processing
  // ------------------------------------------------------------
  logic [2:0] idx;
  logic [W-1:0] cur_base;
  logic signed [W:0] sig_now;
  logic signed [W+1:0] on_lvl;
  logic signed [W+1:0] off_lvl;
  logic above_noise;
  logic below_neg;
  touch_pkg::bl_action_t act;

  assign idx = meas.sensor;
  assign cur_base = base_q[idx];

  // Classify the incoming raw count against the window
  always_comb
  begin
    above_noise = sdiff(meas.raw, cur_base) >
                  $signed({1'b0, tune.noise_th});
    below_neg = sdiff(cur_base, meas.raw) >
                $signed({1'b0, tune.neg_noise_th});
    if (!init_q[idx])
      act = touch_pkg::BL_INIT;
    else if (below_neg)
    begin
      if (low_q[idx] + (`TOUCH_LOWCNT_W)'(1) >= tune.low_reset)
        act = touch_pkg::BL_RELOAD;
      else
        act = touch_pkg::BL_HOLD;
    end
    else if (above_noise && !tune.auto_reset)
      act = touch_pkg::BL_HOLD;
    else
      act = touch_pkg::BL_FILTER;
  end

  // Signal against the baseline the scan is judged by
  always_comb
  begin
    if (act == touch_pkg::BL_INIT || act == touch_pkg::BL_RELOAD)
      sig_now = '0;
    else
      sig_now = sdiff(meas.raw, cur_base);
    on_lvl = $signed({2'b00, tune.finger_th}) + $signed({2'b00, tune.hyst});
    off_lvl = $signed({2'b00, tune.finger_th}) -
              $signed({2'b00, tune.hyst});
  end

  // Next state for baseline, low counter, debounce and touch state
  always_comb
  begin
    base_d = base_q;
    low_d = low_q;
    deb_d = deb_q;
    init_d = init_q;
    on_d = on_q;
    valid_d = 1'b0;
    sens_d = sens_q;
    sig_d = sig_q;
    obase_d = obase_q;
    method_d = method_q;
    if (meas_valid)
    begin
      // Same path whatever the sensing method
      method_d = mutual_cap_method;
      valid_d = 1'b1;
      sens_d = idx;
      sig_d = sig_now;
      unique case (act)
        touch_pkg::BL_INIT:
        begin
          base_d[idx] = meas.raw;
          init_d[idx] = 1'b1;
          low_d[idx] = '0;
        end
        touch_pkg::BL_RELOAD:
        begin
          base_d[idx] = meas.raw;
          low_d[idx] = '0;
        end
        touch_pkg::BL_HOLD:
        begin
          if (below_neg)
            low_d[idx] = low_q[idx] + (`TOUCH_LOWCNT_W)'(1);
          else
            low_d[idx] = '0;
        end
        touch_pkg::BL_FILTER:
        begin
          base_d[idx] = lpf(cur_base, meas.raw, tune.filt_shift);
          low_d[idx] = '0;
        end
      endcase
      obase_d = base_d[idx];
      // Hysteresis and debounce
      if ((W+2)'(sig_now) >= on_lvl)
      begin
        if (deb_q[idx] + (`TOUCH_DEB_W)'(1) >= tune.debounce)
          on_d[idx] = 1'b1;
        else
          deb_d[idx] = deb_q[idx] + (`TOUCH_DEB_W)'(1);
      end
      else
      begin
        deb_d[idx] = '0;
        if ((W+2)'(sig_now) <= off_lvl)
          on_d[idx] = 1'b0;
        // Otherwise state stays as it was
      end
    end
  end

  // State registers
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < N; i++)
      begin
        base_q[i] <= `TOUCH_BASE_RST;
        low_q[i] <= '0;
        deb_q[i] <= '0;
      end
      init_q <= '0;
      on_q <= '0;
      valid_q <= 1'b0;
      sens_q <= '0;
      sig_q <= '0;
      obase_q <= '0;
      method_q <= 1'b0;
    end
    else
    begin
      base_q <= base_d;
      low_q <= low_d;
      deb_q <= deb_d;
      init_q <= init_d;
      on_q <= on_d;
      valid_q <= valid_d;
      sens_q <= sens_d;
      sig_q <= sig_d;
      obase_q <= obase_d;
      method_q <= method_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs and routing
  // ------------------------------------------------------------

  // The sensor just scanned is the active one
  always_comb
  begin
    active_mask = '0;
    active_mask[sens_q] = 1'b1;
  end

  touch_route #(
    .N(N)
  ) u_route (
    .shield_en(shield_en),
    .override_en(override_en),
    .override_mask(override_mask),
    .active_mask(active_mask),
    .to_shield(to_shield),
    .to_ground(to_ground)
  );

  assign touch_on = on_q;
  assign out_valid = valid_q;
  assign out_sensor = sens_q;
  assign out_signal = sig_q;
  assign out_baseline = obase_q;
  assign out_method = method_q;

endmodule

//--- verilog/touch_cfg.svh
/*
  Timing counts, reset values and field widths for the touch baseline
  tracker. Included by bare name; holds definitions only.
*/
`ifndef TOUCH_CFG_SVH
`define TOUCH_CFG_SVH

// ------------------------------------------------------------
// Widths and reset values
// ------------------------------------------------------------
`define TOUCH_COUNT_W 16
`define TOUCH_LOWCNT_W 8
`define TOUCH_DEB_W 4
`define TOUCH_SHIFT_W 3
`define TOUCH_NUM_SENSORS 8
`define TOUCH_BASE_RST 16'h0000
`define TOUCH_LOW_RESET_TYP 8'h1e
`define TOUCH_DEBOUNCE_TYP 4'h3
`define TOUCH_SHIFT_TYP 3'h3

`endif

//--- verilog/touch_pkg.sv
/*
  Types shared by the touch baseline tracker.
  Assumes touch_cfg.svh is on the include path.
*/
`include "touch_cfg.svh"

package touch_pkg;

  // Tuning set shared by all sensors
  typedef struct packed {
    logic [`TOUCH_COUNT_W-1:0] finger_th;
    logic [`TOUCH_COUNT_W-1:0] hyst;
    logic [`TOUCH_COUNT_W-1:0] noise_th;
    logic [`TOUCH_COUNT_W-1:0] neg_noise_th;
    logic [`TOUCH_LOWCNT_W-1:0] low_reset;
    logic [`TOUCH_DEB_W-1:0] debounce;
    logic [`TOUCH_SHIFT_W-1:0] filt_shift;
    logic auto_reset;
  } tune_t;

  // One raw measurement from the front end
  typedef struct packed {
    logic [2:0] sensor;
    logic [`TOUCH_COUNT_W-1:0] raw;
  } meas_t;

  // Baseline decision for one scan
  typedef enum logic [1:0] {
    BL_INIT,
    BL_FILTER,
    BL_HOLD,
    BL_RELOAD
  } bl_action_t;

endpackage

//--- verilog/touch_route.sv
/*
  Inactive sensor routing: picks shield or ground for each sensor that is
  not being scanned. Purely combinational, same clock domain as its user.
*/
`timescale 1ns/100ps

module touch_route #(
  parameter int N = 8
) (
  // Routing control
  input wire logic shield_en,
  input wire logic override_en,
  input wire logic [N-1:0] override_mask,
  input wire logic [N-1:0] active_mask,
  // Pad selection
  output logic [N-1:0] to_shield,
  output logic [N-1:0] to_ground
);

  // Per-sensor tie-off choice
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (active_mask[i])
      begin
        to_shield[i] = 1'b0;
        to_ground[i] = 1'b0;
      end
      else if (override_en)
      begin
        to_shield[i] = override_mask[i];
        to_ground[i] = ~override_mask[i];
      end
      else
      begin
        to_shield[i] = shield_en;
        to_ground[i] = ~shield_en;
      end
    end
  end

endmodule
